// ===== include/mss_pkg.sv
/*
 * Shared constants and types of the motor start/stop sequencer:
 * register map, parameter store layout with limits and defaults,
 * sequencer states, interrupt events and the state record.
 * Assumes a 25 MHz register clock and frequencies in 0.01 Hz units.
 */
package mss_pkg;

   // Clock and time base
   localparam int CLK_PERIOD_NS = 40;
   localparam int TICK_NS       = 1000000;
   localparam int TICK_CYC      = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BRK_UNIT_MS   = 100;

   // Bus geometry
   localparam int ADDR_W = 8;
   localparam int IDX_LSB = 2;

   // Word indices; byte address is four times the index
   localparam logic [5:0] REG_CTRL    = 6'h00;
   localparam logic [5:0] REG_LOCK    = 6'h01;
   localparam logic [5:0] REG_PRM0    = 6'h02;
   localparam logic [5:0] REG_STATUS  = 6'h0f;
   localparam logic [5:0] REG_IRQ_STS = 6'h10;
   localparam logic [5:0] REG_IRQ_MSK = 6'h11;

   // Control register bits
   localparam int CTRL_RUN = 0;
   localparam int CTRL_REV = 1;

   // Status register fields
   localparam int ST_SUSP     = 5;
   localparam int ST_OUT_EN   = 6;
   localparam int ST_DCB_EN   = 7;
   localparam int ST_FWD      = 4;
   localparam int ST_FREQ_LSB = 16;

   // Parameter store
   localparam int NPRM       = 13;
   localparam int P_MAIN     = 0;
   localparam int P_STARTM   = 1;
   localparam int P_STOPM    = 2;
   localparam int P_STARTF   = 3;
   localparam int P_STOPF    = 4;
   localparam int P_SBC      = 5;
   localparam int P_SBT      = 6;
   localparam int P_PBC      = 7;
   localparam int P_PBT      = 8;
   localparam int P_BOOST    = 9;
   localparam int P_RAMP     = 10;
   localparam int P_TOP      = 11;
   localparam int P_OCL      = 12;

   // Index 12 first
   localparam logic [NPRM-1:0][15:0] PRM_DEF = {
      16'h0096, 16'h1388, 16'h0001, 16'h0032, 16'h0000, 16'h0064, 16'h0000,
      16'h0064, 16'h0032, 16'h0032, 16'h0000, 16'h0000, 16'h1388};
   localparam logic [NPRM-1:0][15:0] PRM_MIN = {
      16'h0000, 16'h0000, 16'h0001, 16'h0001, 16'h0000, 16'h0000, 16'h0000,
      16'h0000, 16'h000a, 16'h000a, 16'h0000, 16'h0000, 16'h0000};
   localparam logic [NPRM-1:0][15:0] PRM_MAX = {
      16'h00fa, 16'h9c40, 16'h03e8, 16'h00c8, 16'h00fa, 16'h0096, 16'h00fa,
      16'h0096, 16'h03e8, 16'h03e8, 16'h0001, 16'h0001, 16'h9c40};

   localparam logic [15:0] MODE_ALT = 16'h0001;

   // Interrupt events
   localparam int NEV       = 4;
   localparam int EV_START  = 0;
   localparam int EV_CAUGHT = 1;
   localparam int EV_STOP   = 2;
   localparam int EV_REFUSE = 3;

   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [2:0] {
      MSS_IDLE   = 3'b000,
      MSS_SBRK   = 3'b001,
      MSS_SEARCH = 3'b010,
      MSS_RUN    = 3'b011,
      MSS_DECEL  = 3'b100,
      MSS_PBRK   = 3'b101
   } mss_seq_t;

   typedef struct packed {
      logic        out_en;
      logic        out_fwd;
      logic [15:0] out_freq;
      logic        dcb_en;
      logic [7:0]  dcb_cur;
      logic [7:0]  boost;
   } mss_drive_t;

   typedef struct packed {
      logic                   aw_got;
      logic                   w_got;
      logic [ADDR_W-1:0]      awaddr;
      logic [31:0]            wdata;
      logic [3:0]             wstrb;
      logic                   bvalid;
      logic [1:0]             bresp;
      logic                   rvalid;
      logic [1:0]             rresp;
      logic [31:0]            rdata;
      logic                   run;
      logic                   rev;
      logic                   lock;
      logic [NPRM-1:0][15:0]  prm;
      logic [NEV-1:0]         irq_sts;
      logic [NEV-1:0]         irq_msk;
      mss_seq_t               seq;
      logic [15:0]            cnt;
      logic                   susp;
      logic [7:0]             cur_m;
      logic [7:0]             cur_s;
      logic [1:0]             match_m;
      logic [1:0]             match_s;
      mss_drive_t             drv;
   } mss_state_t;

endpackage

// ===== rtl/mss_tick.sv
/*
 * Time base divider: one-cycle enable pulse every DIV clocks.
 * Assumes a single clock domain and a synchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none

module mss_tick #(
   parameter int DIV = 25000
) (
   // Clock and reset
   input  wire logic aclk,
   input  wire logic aresetn,
   // Enable pulse
   output logic      tick
);

   localparam int CW = $clog2(DIV + 1);
   localparam logic [CW-1:0] LAST = CW'(DIV - 1);

   logic [CW-1:0] cnt_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q <= '0;
         tick  <= 1'b0;
      end else begin
         tick  <= (cnt_q == LAST);
         cnt_q <= (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
      end
   end

endmodule

`default_nettype wire

// ===== rtl/mss_seq.sv
/*
 * Motor start/stop sequencer with AXI4-Lite register slave.
 * Holds the start/stop parameter store, runs pre-start braking,
 * plain or flying start, ramped or coasting stop and stop braking.
 * Assumes motor current, speed-match and rotation sense come from
 * pins outside the clock domain; they are synchronised here.
 */
// Behaviour
// R1 - Start mode 0 starts at start frequency; mode 1 performs flying start.
// R2 - Flying start takes the motor's sensed speed and direction and drives from there.
// R3 - Speed search sweeps output frequency from high down toward low.
// R4 - Search pauses while current exceeds follow level, resumes below it.
// R5 - Stop mode 0 ramps down; stop mode 1 coasts with output removed.
// R6 - Ramped stop lowers frequency at the ramp rate down to stop frequency.
// R7 - At stop frequency apply stop braking if enabled, else output off.
// R8 - Coasting stop removes output at once with no ramp.
// R9 - Start frequency ranges 0.10 to 10.00 Hz in 0.01 steps, default 0.5.
// R10 - Stop frequency ends the ramp; range 0.10 to 10.00, default 0.5.
// R11 - Start brake current 0 to 150 percent of rating, default 100.
// R12 - Start brake time 0 to 250; zero disables pre-start braking.
// R13 - Stop brake current 0 to 150 percent of rating, default 100.
// R14 - Stop brake time 0 to 250; zero disables stop braking.
// R15 - Torque boost 0.1 to 20 percent in 0.1 steps, default 5.
// R16 - Lock set refuses all parameter writes except lock and main frequency.
// R17 - Pre-start braking finishes before frequency output begins.
`timescale 1ns/1ps
`default_nettype none

module mss_seq
   import mss_pkg::*;
#(
   parameter int TICK_DIV = TICK_CYC
) (
   // Clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // AXI4-Lite write address
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic              awvalid,
   output logic                   awready,
   // AXI4-Lite write data
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   // AXI4-Lite write response
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   // AXI4-Lite read address
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic              arvalid,
   output logic                   arready,
   // AXI4-Lite read data
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   // Motor sense pins
   input  wire logic [7:0]        motor_current,
   input  wire logic              speed_match,
   input  wire logic              motor_fwd,
   // Power stage command
   output mss_drive_t             drive,
   // Interrupt
   output logic                   irq
);

   mss_state_t     s_q;
   mss_state_t     s_d;
   logic           tick;
   logic [NEV-1:0] ev;

   mss_tick #(
      .DIV (TICK_DIV)
   ) u_tick (
      .aclk    (aclk),
      .aresetn (aresetn),
      .tick    (tick)
   );

   function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[8*b +: 8] = new_v[8*b +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [15:0] brk_load(input logic [15:0] t);
      return 16'(t * BRK_UNIT_MS);
   endfunction

   function automatic logic [15:0] step_down(input logic [15:0] f, input logic [15:0] st,
                                            input logic [15:0] floor_v);
      return (f > floor_v + st) ? 16'(f - st) : floor_v;
   endfunction

   function automatic logic [31:0] read_word(input mss_state_t s, input logic [5:0] idx);
      logic [31:0] r;
      r = '0;
      if (idx == REG_CTRL) begin
         r[CTRL_RUN] = s.run;
         r[CTRL_REV] = s.rev;
      end else if (idx == REG_LOCK) begin
         r[0] = s.lock;
      end else if (idx >= REG_PRM0 && idx < REG_STATUS) begin
         r[15:0] = s.prm[idx - REG_PRM0];
      end else if (idx == REG_STATUS) begin
         r[2:0]                    = s.seq;
         r[ST_FWD]                 = s.drv.out_fwd;
         r[ST_SUSP]                = s.susp;
         r[ST_OUT_EN]              = s.drv.out_en;
         r[ST_DCB_EN]              = s.drv.dcb_en;
         r[ST_FREQ_LSB +: 16]      = s.drv.out_freq;
      end else if (idx == REG_IRQ_STS) begin
         r[NEV-1:0] = s.irq_sts;
      end else if (idx == REG_IRQ_MSK) begin
         r[NEV-1:0] = s.irq_msk;
      end
      return r;
   endfunction

   function automatic logic idx_mapped(input logic [5:0] idx);
      return idx <= REG_IRQ_MSK;
   endfunction

   assign awready = !s_q.aw_got && !s_q.bvalid;
   assign wready  = !s_q.w_got && !s_q.bvalid;
   assign arready = !s_q.rvalid;
   assign bvalid  = s_q.bvalid;
   assign bresp   = s_q.bresp;
   assign rvalid  = s_q.rvalid;
   assign rresp   = s_q.rresp;
   assign rdata   = s_q.rdata;
   assign drive   = s_q.drv;
   assign irq     = |(s_q.irq_sts & s_q.irq_msk);

   always_comb begin
      logic [5:0]  widx;
      logic [5:0]  ridx;
      logic [31:0] wv;
      logic [3:0]  pi;
      logic [NEV-1:0] clr;
      logic        stop_now;
      logic        start_now;
      s_d       = s_q;
      ev        = '0;
      clr       = '0;
      stop_now  = 1'b0;
      start_now = 1'b0;
      widx      = s_q.awaddr[ADDR_W-1:IDX_LSB];
      ridx      = araddr[ADDR_W-1:IDX_LSB];
      wv        = merge(read_word(s_q, widx), s_q.wdata, s_q.wstrb);
      pi        = 4'(widx - REG_PRM0);

      // Pin inputs pass two flip-flops before anything reads them
      s_d.cur_m   = motor_current;
      s_d.cur_s   = s_q.cur_m;
      s_d.match_m = {motor_fwd, speed_match};
      s_d.match_s = s_q.match_m;

      // Read channel
      if (s_q.rvalid && rready) begin
         s_d.rvalid = 1'b0;
      end
      if (arvalid && arready) begin
         s_d.rvalid = 1'b1;
         s_d.rdata  = read_word(s_q, ridx);
         s_d.rresp  = idx_mapped(ridx) ? RESP_OKAY : RESP_SLVERR;
      end

      // Write channel: address and data taken in either order
      if (awvalid && awready) begin
         s_d.aw_got = 1'b1;
         s_d.awaddr = awaddr;
      end
      if (wvalid && wready) begin
         s_d.w_got = 1'b1;
         s_d.wdata = wdata;
         s_d.wstrb = wstrb;
      end
      if (s_q.bvalid && bready) begin
         s_d.bvalid = 1'b0;
      end
      if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
         s_d.aw_got = 1'b0;
         s_d.w_got  = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp  = RESP_OKAY;
         if (widx == REG_CTRL) begin
            s_d.run = wv[CTRL_RUN];
            s_d.rev = wv[CTRL_REV];
         end else if (widx == REG_LOCK) begin
            s_d.lock = wv[0];                                                  // R16
         end else if (widx >= REG_PRM0 && widx < REG_STATUS) begin
            // Refused writes still answer OKAY; the event flag reports them
            if (s_q.lock && pi != 4'(P_MAIN)) begin
               ev[EV_REFUSE] = 1'b1;                                           // R16
            end else if (wv[15:0] < PRM_MIN[pi] || wv[15:0] > PRM_MAX[pi]) begin
               ev[EV_REFUSE] = 1'b1;                                           // R9 R10 R11 R12 R13 R14 R15
            end else begin
               s_d.prm[pi] = wv[15:0];
            end
         end else if (widx == REG_IRQ_STS) begin
            clr = wv[NEV-1:0];
         end else if (widx == REG_IRQ_MSK) begin
            s_d.irq_msk = wv[NEV-1:0];
         end else if (widx != REG_STATUS) begin
            s_d.bresp = RESP_SLVERR;
         end
      end

      // Sequencer
      s_d.susp = 1'b0;
      unique case (s_q.seq)
         MSS_IDLE: begin
            if (s_q.run) begin
               if (s_q.prm[P_SBT] != '0) begin
                  s_d.seq = MSS_SBRK;                                          // R12 R17
                  s_d.cnt = brk_load(s_q.prm[P_SBT]);
               end else begin
                  start_now = 1'b1;
               end
            end
         end
         MSS_SBRK: begin
            if (!s_q.run) begin
               s_d.seq = MSS_IDLE;
            end else if (tick) begin
               s_d.cnt = s_q.cnt - 1'b1;
               if (s_q.cnt <= 16'h0001) begin
                  start_now = 1'b1;                                            // R17
               end
            end
         end
         MSS_SEARCH: begin
            s_d.susp = s_q.cur_s > s_q.prm[P_OCL][7:0];                        // R4
            if (!s_q.run) begin
               stop_now = 1'b1;
            end else if (s_q.match_s[0]) begin
               // Motor speed tracked: drive on from the caught state
               s_d.seq         = MSS_RUN;                                      // R2
               s_d.drv.out_fwd = s_q.match_s[1];                               // R2
               ev[EV_CAUGHT]   = 1'b1;
            end else if (tick && !s_d.susp) begin
               s_d.drv.out_freq = step_down(s_q.drv.out_freq, s_q.prm[P_RAMP],
                                            s_q.prm[P_STARTF]);                 // R3
               // Nothing caught down to the floor: treat the motor as standing
               if (s_q.drv.out_freq == s_q.prm[P_STARTF]) begin
                  s_d.seq       = MSS_RUN;
                  ev[EV_CAUGHT] = 1'b1;
               end
            end
         end
         MSS_RUN: begin
            if (!s_q.run) begin
               stop_now = 1'b1;
            end else if (tick) begin
               if (s_q.drv.out_freq > s_q.prm[P_MAIN]) begin
                  s_d.drv.out_freq = step_down(s_q.drv.out_freq, s_q.prm[P_RAMP], s_q.prm[P_MAIN]);
               end else if (s_q.prm[P_MAIN] > s_q.drv.out_freq + s_q.prm[P_RAMP]) begin
                  s_d.drv.out_freq = 16'(s_q.drv.out_freq + s_q.prm[P_RAMP]);
               end else begin
                  s_d.drv.out_freq = s_q.prm[P_MAIN];
               end
            end
         end
         MSS_DECEL: begin
            if (s_q.run) begin
               s_d.seq = MSS_RUN;
            end else if (s_q.drv.out_freq <= s_q.prm[P_STOPF]) begin
               if (s_q.prm[P_PBT] != '0) begin
                  s_d.seq = MSS_PBRK;                                          // R7 R14
                  s_d.cnt = brk_load(s_q.prm[P_PBT]);
               end else begin
                  s_d.seq      = MSS_IDLE;                                     // R7
                  ev[EV_STOP]  = 1'b1;
               end
            end else if (tick) begin
               s_d.drv.out_freq = step_down(s_q.drv.out_freq, s_q.prm[P_RAMP],
                                            s_q.prm[P_STOPF]);                  // R6 R10
            end
         end
         MSS_PBRK: begin
            // A new run command waits until the stop brake has ended
            if (tick) begin
               s_d.cnt = s_q.cnt - 1'b1;
               if (s_q.cnt <= 16'h0001) begin
                  s_d.seq     = MSS_IDLE;
                  ev[EV_STOP] = 1'b1;
               end
            end
         end
         default: begin
            s_d.seq = MSS_IDLE;
         end
      endcase

      if (start_now) begin
         ev[EV_START]    = 1'b1;
         s_d.drv.out_fwd = !s_q.rev;
         if (s_q.prm[P_STARTM] == MODE_ALT) begin
            s_d.seq          = MSS_SEARCH;                                     // R1 R3
            s_d.drv.out_freq = s_q.prm[P_TOP];
         end else begin
            s_d.seq          = MSS_RUN;                                        // R1 R9
            s_d.drv.out_freq = s_q.prm[P_STARTF];
         end
      end
      if (stop_now) begin
         if (s_q.prm[P_STOPM] == MODE_ALT) begin
            s_d.seq     = MSS_IDLE;                                            // R5 R8
            ev[EV_STOP] = 1'b1;
         end else begin
            s_d.seq = MSS_DECEL;                                               // R5 R6
         end
      end

      // Drive outputs registered from the next state
      s_d.drv.out_en  = (s_d.seq == MSS_SEARCH) || (s_d.seq == MSS_RUN) || (s_d.seq == MSS_DECEL);
      s_d.drv.dcb_en  = (s_d.seq == MSS_SBRK) || (s_d.seq == MSS_PBRK);
      s_d.drv.dcb_cur = (s_d.seq == MSS_SBRK) ? s_q.prm[P_SBC][7:0] :          // R11
                        (s_d.seq == MSS_PBRK) ? s_q.prm[P_PBC][7:0] : 8'h00;   // R13
      s_d.drv.boost   = s_d.drv.out_en ? s_q.prm[P_BOOST][7:0] : 8'h00;        // R15
      if (!s_d.drv.out_en) begin
         s_d.drv.out_freq = '0;
      end

      // Set wins over a clear in the same cycle
      s_d.irq_sts = (s_q.irq_sts & ~clr) | ev;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q     <= '0;
         s_q.prm <= PRM_DEF;
      end else begin
         s_q <= s_d;
      end
   end

endmodule

`default_nettype wire

// ===== sim/mss_seq_assertions.sv
/* Port checker for mss_seq: bus handshakes and drive relations.
   Assumes one clock aclk and a synchronous active-low aresetn. */
`timescale 1ns/1ps
`default_nettype none
module mss_seq_chk
   import mss_pkg::*;
(
   // Clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // Register bus
   input wire logic        awvalid,
   input wire logic        awready,
   input wire logic        wvalid,
   input wire logic        wready,
   input wire logic [1:0]  bresp,
   input wire logic        bvalid,
   input wire logic        bready,
   input wire logic        arvalid,
   input wire logic        arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0]  rresp,
   input wire logic        rvalid,
   input wire logic        rready,
   // Drive and interrupt
   input wire mss_drive_t  drive,
   input wire logic        irq
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   AST_WR_RESP: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
      else $error("write response late");
   AST_RD_RESP: assert property (arvalid && arready |=> rvalid)
      else $error("read data late");
   AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped");
   AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
      else $error("read data dropped");
   AST_B_BUSY: assert property (bvalid |-> !awready && !wready)
      else $error("write taken while response pending");
   AST_BRK_EXCL: assert property (drive.dcb_en |-> !drive.out_en)
      else $error("braking while output on");
   AST_BRK_CUR: assert property (drive.dcb_en |-> drive.dcb_cur <= 8'h96)
      else $error("brake current out of range");
   AST_FREQ_STEP: assert property (drive.out_en && $past(drive.out_en) |->
      drive.out_freq - $past(drive.out_freq) <= 16'h03e8 || $past(drive.out_freq) - drive.out_freq <= 16'h03e8)
      else $error("frequency jumped");
   AST_BOOST: assert property (drive.out_en |-> drive.boost inside {[8'h01:8'hc8]})
      else $error("boost out of range");
   AST_RST_QUIET: assert property ($rose(aresetn) |-> drive == '0 && !irq)
      else $error("outputs active after reset");

   cover property ($fell(drive.dcb_en));
   cover property (bvalid && bresp == RESP_SLVERR);
   cover property ($rose(irq));
endmodule

bind mss_seq mss_seq_chk i_chk (.*);
`default_nettype wire

// ===== sim/mss_motor.sv
/* Motor behind the power stage.
   Assumes the bench raises overload. */
`timescale 1ns/1ps
`default_nettype none
module mss_motor
   import mss_pkg::*;
#(
   parameter logic [15:0] CATCH_F = 16'h00f0
) (
   // Clock
   input  wire logic        aclk,
   // Power stage command and stress
   input  wire mss_drive_t  drive,
   input  wire logic        overload,
   // Sensed quantities
   output logic [7:0]       motor_current = 8'h00,
   output logic             speed_match = 1'b0,
   output logic             motor_fwd = 1'b0
);
   // Coasting rotor turns in reverse
   always_ff @(posedge aclk) begin
      motor_current <= overload ? 8'hc8 : (drive.out_en || drive.dcb_en) ? 8'h28 : 8'h00;
      speed_match   <= drive.out_en && drive.out_freq <= CATCH_F;
      motor_fwd     <= 1'b0;
   end
endmodule
`default_nettype wire

// ===== sim/mss_seq_tb_top.sv
/* Bench for mss_seq: register rows, then sequences against a motor model.
   Assumes TDIV cycles per tick. */
`timescale 1ns/1ps
`default_nettype none
module mss_seq_tb_top
   import mss_pkg::*;
();
   localparam int TDIV = 4;
   typedef struct packed {
      logic        wr;
      logic [7:0]  a;
      logic [15:0] d;
      logic        e;
      logic [15:0] rd;
   } mss_row_t;
   localparam mss_row_t ROWS [15] = '{
      '{1'b0, 8'h0c, 16'h0000, 1'b0, 16'h0000},
      '{1'b0, 8'h10, 16'h0000, 1'b0, 16'h0000},
      '{1'b0, 8'h18, 16'h0000, 1'b0, 16'h0032},
      '{1'b0, 8'h24, 16'h0000, 1'b0, 16'h0064},
      '{1'b0, 8'h28, 16'h0000, 1'b0, 16'h0000},
      '{1'b1, 8'h14, 16'h0009, 1'b0, 16'h0032},
      '{1'b1, 8'h14, 16'h03e9, 1'b0, 16'h0032},
      '{1'b1, 8'h14, 16'h0014, 1'b0, 16'h0014},
      '{1'b1, 8'h1c, 16'h0097, 1'b0, 16'h0064},
      '{1'b1, 8'h1c, 16'h0096, 1'b0, 16'h0096},
      '{1'b1, 8'h20, 16'h00fb, 1'b0, 16'h0000},
      '{1'b1, 8'h2c, 16'h0000, 1'b0, 16'h0032},
      '{1'b1, 8'h2c, 16'h00c8, 1'b0, 16'h00c8},
      '{1'b1, 8'h18, 16'h000a, 1'b0, 16'h000a},
      '{1'b1, 8'h48, 16'h0001, 1'b1, 16'h0000}};
   logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic        arvalid = 1'b0, rready = 1'b0, overload = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, irq, speed_match, motor_fwd, dseen;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00, motor_current, bc;
   logic [31:0] wdata = 32'h0, rdata, rd;
   logic [1:0]  bresp, rresp, rsp;
   logic [15:0] lf, f1;
   mss_drive_t  drive, snap;
   int          n, checks = 0, mismatches = 0;

   mss_seq #(.TICK_DIV(TDIV)) i_dut (.wstrb(4'hf), .*);
   mss_motor i_motor (.*);

   initial forever #20 aclk = ~aclk;

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         mismatches++;
         $display("CHECK FAILED at %0t got %h exp %h", $time, g, e);
      end
   endtask

   // Ready is judged at the falling edge, clear of the update
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      logic pa, pw;
      pa = 1'b1;
      pw = 1'b1;
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      while (pa || pw) begin
         @(negedge aclk);
         pa = pa && !awready;
         pw = pw && !wready;
         @(posedge aclk);
         awvalid <= pa;
         wvalid  <= pw;
      end
      // Late bready holds the response
      repeat (2) @(posedge aclk);
      bready <= 1'b1;
      do @(negedge aclk); while (!bvalid);
      rsp = bresp;
      @(posedge aclk);
      bready <= 1'b0;
   endtask

   task automatic axr(input logic [7:0] a);
      araddr  <= a;
      arvalid <= 1'b1;
      do @(negedge aclk); while (!arready);
      @(posedge aclk);
      arvalid <= 1'b0;
      repeat (2) @(posedge aclk);
      rready <= 1'b1;
      do @(negedge aclk); while (!rvalid);
      rd  = rdata;
      rsp = rresp;
      @(posedge aclk);
      rready <= 1'b0;
   endtask

   // Wait on output, braking or main frequency
   task automatic waitfor(input int sel, input logic v);
      n = 0;
      dseen = 1'b0;
      do begin
         @(negedge aclk);
         n++;
         snap = drive;
         dseen |= drive.dcb_en;
         if (drive.out_en) lf = drive.out_freq;
         if (drive.dcb_en) bc = drive.dcb_cur;
      end while ((sel == 0 ? snap.out_en : sel == 1 ? snap.dcb_en : snap.out_freq == 16'h3c) !== v);
      @(posedge aclk);
   endtask

   initial begin
      repeat (20000) @(posedge aclk);
      mismatches++;
      report_and_stop();
   end

   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      foreach (ROWS[i]) begin
         if (ROWS[i].wr) begin
            axw(ROWS[i].a, 32'(ROWS[i].d));
            chk(32'(rsp), {30'h0, ROWS[i].e, 1'b0});
         end
         axr(ROWS[i].a);
         chk(rd & 32'hffff, 32'(ROWS[i].rd));
         chk(32'(rsp), {30'h0, ROWS[i].e, 1'b0});
      end
      $display("register table test done");
      axw(8'h44, 32'h0);
      axw(8'h04, 32'h1);
      axw(8'h14, 32'h1e);
      axw(8'h08, 32'h3c);
      axr(8'h14);
      chk(rd & 32'hffff, 32'h14);
      axr(8'h08);
      chk(rd & 32'hffff, 32'h3c);
      axr(8'h40);
      chk(32'(rd[3]), 32'h1);
      chk(32'(irq), 32'h0);
      axw(8'h44, 32'h8);
      chk(32'(irq), 32'h1);
      axw(8'h40, 32'h8);
      chk(32'(irq), 32'h0);
      axw(8'h04, 32'h0);
      $display("lock and interrupt test done");
      axw(8'h20, 32'h1);
      axw(8'h00, 32'h1);
      waitfor(0, 1'b1);
      chk(32'(n >= 98 * TDIV && n <= 101 * TDIV + 8), 32'h1);
      chk(32'(bc), 32'h96);
      chk(32'(snap.out_freq), 32'h14);
      chk(32'(snap.dcb_en), 32'h0);
      chk(32'(snap.boost), 32'hc8);
      waitfor(2, 1'b1);
      $display("start brake test done");
      axw(8'h24, 32'h40);
      axw(8'h28, 32'h1);
      axw(8'h00, 32'h0);
      waitfor(1, 1'b1);
      chk(32'(lf), 32'h0a);
      chk(32'(n >= 45 * TDIV), 32'h1);
      chk(32'(snap.out_en), 32'h0);
      chk(32'(snap.dcb_cur), 32'h40);
      waitfor(1, 1'b0);
      chk(32'(n >= 98 * TDIV && n <= 101 * TDIV + 8), 32'h1);
      $display("ramped stop with brake test done");
      axw(8'h20, 32'h0);
      axw(8'h28, 32'h0);
      axw(8'h00, 32'h1);
      waitfor(0, 1'b1);
      chk(32'(dseen || n > 8), 32'h0);
      axw(8'h00, 32'h0);
      waitfor(0, 1'b0);
      chk(32'(lf), 32'h0a);
      axr(8'h3c);
      chk(rd & 32'h87, 32'h0);
      $display("ramped stop without brake test done");
      axw(8'h10, 32'h1);
      axw(8'h00, 32'h1);
      waitfor(2, 1'b1);
      axw(8'h00, 32'h0);
      waitfor(0, 1'b0);
      chk(32'(lf), 32'h3c);
      chk(32'(n <= 2 && !dseen), 32'h1);
      $display("coast stop test done");
      axw(8'h0c, 32'h1);
      axw(8'h34, 32'h100);
      axw(8'h38, 32'h64);
      axw(8'h00, 32'h1);
      waitfor(0, 1'b1);
      chk(32'(snap.out_freq), 32'h100);
      overload <= 1'b1;
      // Motor model and synchroniser lag
      repeat (8) @(posedge aclk);
      axr(8'h3c);
      f1 = rd[31:16];
      chk(32'(rd[5]), 32'h1);
      repeat (10 * TDIV) @(posedge aclk);
      axr(8'h3c);
      chk(32'(rd[31:16]), 32'(f1));
      overload <= 1'b0;
      repeat (3 * TDIV) @(posedge aclk);
      axr(8'h3c);
      chk(32'(rd[31:16] < f1), 32'h1);
      do axr(8'h3c); while (rd[2:0] !== 3'h3);
      chk(32'(rd[4]), 32'h0);
      chk(32'(rd[31:16] <= 16'hf0), 32'h1);
      axr(8'h40);
      chk(32'(rd[1]), 32'h1);
      axw(8'h00, 32'h0);
      $display("flying start test done");
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk(32'(drive == '0), 32'h1);
      axr(8'h14);
      chk(rd & 32'hffff, 32'h32);
      $display("reset test done");
      report_and_stop();
   end
endmodule
`default_nettype wire
